// ### verilog/ioc_defines.vh
// Register map, field positions, reset values and timing counts for oscillator control
`ifndef IOC_DEFINES_VH
`define IOC_DEFINES_VH

`define IOC_OFF_INT_MASK     12'h000
`define IOC_OFF_INT_STAT     12'h004
`define IOC_OFF_CLK_STAT     12'h00c
`define IOC_OFF_SLOW_CTRL    12'h018
`define IOC_OFF_ULP_CTRL     12'h01c
`define IOC_OFF_FAST_CTRL    12'h020

`define IOC_SLOW_TRIM_LSB    16
`define IOC_SLOW_LOCK_BIT    12
`define IOC_SLOW_START_LSB   8
`define IOC_DEMAND_BIT       7
`define IOC_STDBY_BIT        6
`define IOC_OUT32K_BIT       2
`define IOC_ENABLE_BIT       1
`define IOC_ULP_LOCK_BIT     7
`define IOC_FAST_BAND_LSB    30
`define IOC_FAST_TRIM_LSB    16
`define IOC_FAST_DIV_LSB     8

`define IOC_SLOW_TRIM_RST    7'h3f
`define IOC_SLOW_START_RST   3'h0
`define IOC_SLOW_DEMAND_RST  1'b1
`define IOC_FAST_DIV_RST     2'h3
`define IOC_FAST_DEMAND_RST  1'b1
`define IOC_FAST_ENABLE_RST  1'b1

`define IOC_START_BASE       8'h02
`define IOC_SYNC_CYCLES      2'h2

`define IOC_IRQ_READY_BIT    0
`define IOC_IRQ_LOST_BIT     1

`endif

// ### verilog/ioc_top.v
// Internal oscillator control block with AHB-Lite register slave
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ioc_defines.vh"

module ioc_top
(
	input  wire        i_mclk,
	input  wire        i_rst_n,
	input  wire        i_hsel,
	input  wire [11:0] i_haddr,
	input  wire [1:0]  i_htrans,
	input  wire        i_hwrite,
	input  wire [2:0]  i_hsize,
	input  wire [31:0] i_hwdata,
	input  wire        i_hready,
	output reg  [31:0] o_hrdata,
	output reg         o_hreadyout,
	output reg         o_hresp,
	input  wire        i_ulp_clk,
	input  wire        i_slow_osc_clk,
	input  wire        i_standby,
	input  wire        i_slow_clk_req,
	input  wire        i_fast_clk_req,
	input  wire [4:0]  i_ulp_trim_cal,
	input  wire [1:0]  i_fast_band_cal,
	input  wire [11:0] i_fast_trim_cal,
	output reg         o_slow_osc_run,
	output reg  [6:0]  o_slow_osc_trim,
	output reg         o_out32k_enable,
	output reg         o_slow_int_ready,
	output reg  [4:0]  o_ulp_osc_trim,
	output reg         o_fast_osc_run,
	output reg  [1:0]  o_fast_freq_band,
	output reg  [11:0] o_fast_osc_trim,
	output reg  [3:0]  o_fast_div_ratio,
	output reg         o_irq
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function [7:0] startup_len;
	input [2:0] code;
	begin
		startup_len = (8'h01 << code) + `IOC_START_BASE;
	end
endfunction

function run_gate;
	input en;
	input demand;
	input keep;
	input req;
	input stdby;
	begin
		run_gate = en & (~stdby | keep) & (~demand | req);
	end
endfunction

localparam [1:0] ST_IDLE  = 2'h0;
localparam [1:0] ST_COUNT = 2'h1;
localparam [1:0] ST_SYNC  = 2'h2;
localparam [1:0] ST_READY = 2'h3;

////////////////////////////////////////////////////////////////////////////////
// Register state

reg  [6:0]  slow_trim_q;
reg         slow_lock_q;
reg  [2:0]  slow_start_q;
reg         slow_demand_q;
reg         slow_keep_q;
reg         slow_out32k_q;
reg         slow_en_q;
reg         ulp_lock_q;
reg  [4:0]  ulp_trim_q;
reg  [1:0]  fast_band_q;
reg  [11:0] fast_trim_q;
reg  [1:0]  fast_div_q;
reg         fast_demand_q;
reg         fast_keep_q;
reg         fast_en_q;
reg         cal_loaded_q;
reg  [1:0]  int_mask_q;
reg  [1:0]  int_stat_q;
reg         wr_pend_q;
reg  [11:0] wr_addr_q;
reg  [1:0]  state_q;
reg  [7:0]  cnt_q;
reg  [2:0]  ulp_sync_q;
reg  [2:0]  slow_sync_q;
reg         ready_q;

wire        slow_run_d;
wire        fast_run_d;
wire        addr_ok;
wire        rd_req;
wire        ulp_edge;
wire        slow_edge;
wire        ready_rise;
wire        ready_fall;
wire        stat_rd;
reg  [31:0] rd_mux;

////////////////////////////////////////////////////////////////////////////////
// Bus decode

assign addr_ok = i_hsel & i_htrans[1] & i_hready;
assign rd_req  = addr_ok & ~i_hwrite;
assign stat_rd = rd_req & (i_haddr == `IOC_OFF_INT_STAT);

always @*
begin
	rd_mux = 32'h0000_0000;
	case (i_haddr)
		`IOC_OFF_INT_MASK:  rd_mux[1:0] = int_mask_q;
		`IOC_OFF_INT_STAT:  rd_mux[1:0] = int_stat_q;
		`IOC_OFF_CLK_STAT:  rd_mux[0] = ready_q;
		`IOC_OFF_SLOW_CTRL:
		begin
			rd_mux[`IOC_SLOW_TRIM_LSB +: 7]  = slow_trim_q;
			rd_mux[`IOC_SLOW_LOCK_BIT]       = slow_lock_q;
			rd_mux[`IOC_SLOW_START_LSB +: 3] = slow_start_q;
			rd_mux[`IOC_DEMAND_BIT]          = slow_demand_q;
			rd_mux[`IOC_STDBY_BIT]           = slow_keep_q;
			rd_mux[`IOC_OUT32K_BIT]          = slow_out32k_q;
			rd_mux[`IOC_ENABLE_BIT]          = slow_en_q;
		end
		`IOC_OFF_ULP_CTRL:
		begin
			rd_mux[`IOC_ULP_LOCK_BIT] = ulp_lock_q;
			rd_mux[4:0]               = ulp_trim_q;
		end
		`IOC_OFF_FAST_CTRL:
		begin
			rd_mux[`IOC_FAST_BAND_LSB +: 2] = fast_band_q;
			rd_mux[`IOC_FAST_TRIM_LSB +: 12] = fast_trim_q;
			rd_mux[`IOC_FAST_DIV_LSB +: 2]  = fast_div_q;
			rd_mux[`IOC_DEMAND_BIT]         = fast_demand_q;
			rd_mux[`IOC_STDBY_BIT]          = fast_keep_q;
			rd_mux[`IOC_ENABLE_BIT]         = fast_en_q;
		end
		default:            rd_mux = 32'h0000_0000;
	endcase
end

always @(posedge i_mclk)
begin
	if (!i_rst_n)
	begin
		wr_pend_q   <= 1'b0;
		wr_addr_q   <= 12'h000;
		o_hrdata    <= 32'h0000_0000;
		o_hreadyout <= 1'b1;
		o_hresp     <= 1'b0;
	end
	else
	begin
		wr_pend_q   <= addr_ok & i_hwrite;
		wr_addr_q   <= i_haddr;
		o_hreadyout <= 1'b1;
		o_hresp     <= 1'b0;
		if (rd_req)
			o_hrdata <= rd_mux;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control registers

always @(posedge i_mclk)
begin
	if (!i_rst_n)
	begin
		slow_trim_q   <= `IOC_SLOW_TRIM_RST;
		slow_lock_q   <= 1'b0;
		slow_start_q  <= `IOC_SLOW_START_RST;
		slow_demand_q <= `IOC_SLOW_DEMAND_RST;
		slow_keep_q   <= 1'b0;
		slow_out32k_q <= 1'b0;
		slow_en_q     <= 1'b0;
		ulp_lock_q    <= 1'b0;
		ulp_trim_q    <= 5'h00;
		fast_band_q   <= 2'h0;
		fast_trim_q   <= 12'h000;
		fast_div_q    <= `IOC_FAST_DIV_RST;
		fast_demand_q <= `IOC_FAST_DEMAND_RST;
		fast_keep_q   <= 1'b0;
		fast_en_q     <= `IOC_FAST_ENABLE_RST;
		cal_loaded_q  <= 1'b0;
		int_mask_q    <= 2'h0;
	end
	else if (!cal_loaded_q)
	begin
		cal_loaded_q <= 1'b1;
		ulp_trim_q   <= i_ulp_trim_cal;
		fast_band_q  <= i_fast_band_cal;
		fast_trim_q  <= i_fast_trim_cal;
	end
	else if (wr_pend_q)
	begin
		case (wr_addr_q)
			`IOC_OFF_INT_MASK:  int_mask_q <= i_hwdata[1:0];
			`IOC_OFF_SLOW_CTRL:
				if (!slow_lock_q)
				begin
					slow_trim_q   <= i_hwdata[`IOC_SLOW_TRIM_LSB +: 7];
					slow_lock_q   <= i_hwdata[`IOC_SLOW_LOCK_BIT];
					slow_start_q  <= i_hwdata[`IOC_SLOW_START_LSB +: 3];
					slow_demand_q <= i_hwdata[`IOC_DEMAND_BIT];
					slow_keep_q   <= i_hwdata[`IOC_STDBY_BIT];
					slow_out32k_q <= i_hwdata[`IOC_OUT32K_BIT];
					slow_en_q     <= i_hwdata[`IOC_ENABLE_BIT];
				end
			`IOC_OFF_ULP_CTRL:
				if (!ulp_lock_q)
				begin
					ulp_lock_q <= i_hwdata[`IOC_ULP_LOCK_BIT];
					ulp_trim_q <= i_hwdata[4:0];
				end
			`IOC_OFF_FAST_CTRL:
			begin
				fast_band_q   <= i_hwdata[`IOC_FAST_BAND_LSB +: 2];
				fast_trim_q   <= i_hwdata[`IOC_FAST_TRIM_LSB +: 12];
				fast_div_q    <= i_hwdata[`IOC_FAST_DIV_LSB +: 2];
				fast_demand_q <= i_hwdata[`IOC_DEMAND_BIT];
				fast_keep_q   <= i_hwdata[`IOC_STDBY_BIT];
				fast_en_q     <= i_hwdata[`IOC_ENABLE_BIT];
			end
			default:            int_mask_q <= int_mask_q;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Run gating and outputs

assign slow_run_d = run_gate(slow_en_q, slow_demand_q, slow_keep_q, i_slow_clk_req, i_standby);
assign fast_run_d = run_gate(fast_en_q, fast_demand_q, fast_keep_q, i_fast_clk_req, i_standby);

always @(posedge i_mclk)
begin
	if (!i_rst_n)
	begin
		o_slow_osc_run   <= 1'b0;
		o_fast_osc_run   <= 1'b0;
		o_out32k_enable  <= 1'b0;
		o_slow_osc_trim  <= 7'h00;
		o_ulp_osc_trim   <= 5'h00;
		o_fast_freq_band <= 2'h0;
		o_fast_osc_trim  <= 12'h000;
		o_fast_div_ratio <= 4'h1;
		o_slow_int_ready <= 1'b0;
		o_irq            <= 1'b0;
	end
	else
	begin
		o_slow_osc_run   <= slow_run_d;
		o_fast_osc_run   <= fast_run_d;
		o_out32k_enable  <= slow_out32k_q & slow_run_d;
		o_slow_osc_trim  <= slow_trim_q;
		o_ulp_osc_trim   <= ulp_trim_q;
		o_fast_freq_band <= fast_band_q;
		o_fast_osc_trim  <= fast_trim_q;
		o_fast_div_ratio <= 4'h1 << fast_div_q;
		o_slow_int_ready <= ready_q;
		o_irq            <= |(int_stat_q & int_mask_q);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Start-up counter and ready flag

assign ulp_edge  = ulp_sync_q[1] & ~ulp_sync_q[2];
assign slow_edge = slow_sync_q[1] & ~slow_sync_q[2];

always @(posedge i_mclk)
begin
	if (!i_rst_n)
	begin
		ulp_sync_q  <= 3'h0;
		slow_sync_q <= 3'h0;
		state_q     <= ST_IDLE;
		cnt_q       <= 8'h00;
		ready_q     <= 1'b0;
	end
	else
	begin
		ulp_sync_q  <= {ulp_sync_q[1:0], i_ulp_clk};
		slow_sync_q <= {slow_sync_q[1:0], i_slow_osc_clk};
		if (!slow_run_d)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= 8'h00;
			ready_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					cnt_q   <= 8'h00;
					state_q <= ST_COUNT;
				end
				ST_COUNT:
					if (ulp_edge)
					begin
						if (cnt_q + 8'h01 >= startup_len(slow_start_q))
						begin
							cnt_q   <= 8'h00;
							state_q <= ST_SYNC;
						end
						else
							cnt_q <= cnt_q + 8'h01;
					end
				ST_SYNC:
					if (slow_edge)
					begin
						if (cnt_q[1:0] + 2'h1 >= `IOC_SYNC_CYCLES)
						begin
							state_q <= ST_READY;
							ready_q <= 1'b1;
						end
						else
							cnt_q <= cnt_q + 8'h01;
					end
				ST_READY:
					ready_q <= 1'b1;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt status, cleared by read, set wins

assign ready_rise = (state_q == ST_SYNC) & slow_run_d & slow_edge
	& (cnt_q[1:0] + 2'h1 >= `IOC_SYNC_CYCLES);
assign ready_fall = ready_q & ~slow_run_d;

always @(posedge i_mclk)
begin
	if (!i_rst_n)
		int_stat_q <= 2'h0;
	else
	begin
		int_stat_q[`IOC_IRQ_READY_BIT] <= ready_rise
			| (int_stat_q[`IOC_IRQ_READY_BIT] & ~stat_rd);
		int_stat_q[`IOC_IRQ_LOST_BIT]  <= ready_fall
			| (int_stat_q[`IOC_IRQ_LOST_BIT] & ~stat_rd);
	end
end

endmodule
`default_nettype wire

// ### test/ioc_top_checker.sv
// Port assertions for the oscillator control block
`timescale 1ns/1ps
`default_nettype none
module ioc_top_checker
(
	input wire logic       i_mclk,
	input wire logic       i_rst_n,
	input wire logic       i_ulp_clk,
	input wire logic       o_hreadyout,
	input wire logic       o_hresp,
	input wire logic       o_slow_osc_run,
	input wire logic       o_out32k_enable,
	input wire logic       o_slow_int_ready,
	input wire logic [3:0] o_fast_div_ratio
);
	logic       ulp_q;
	logic [7:0] edge_cnt_q;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// Raw ultra-low edges seen while running
	always @(posedge i_mclk)
	begin
		ulp_q <= i_ulp_clk;
		if (!o_slow_osc_run)
			edge_cnt_q <= 8'h00;
		else if (i_ulp_clk && !ulp_q && edge_cnt_q != 8'hff)
			edge_cnt_q <= edge_cnt_q + 8'h01;
	end
	AST_READY_NEEDS_RUN: assert property (o_slow_int_ready |-> $past(o_slow_osc_run))
		else $error("ready without run");
	AST_READY_ULP_EDGES: assert property ($rose(o_slow_int_ready) |-> edge_cnt_q >= 8'h02)
		else $error("ready too early");
	AST_READY_RUN_HOLD: assert property ($rose(o_slow_int_ready) |-> $past(o_slow_osc_run, 8))
		else $error("ready before start-up");
	AST_READY_DROPS: assert property ($fell(o_slow_osc_run) |-> ##[0:2] !o_slow_int_ready)
		else $error("ready kept after stop");
	AST_NO_READY_START: assert property ($rose(o_slow_osc_run) |=> !o_slow_int_ready [*2])
		else $error("ready at start");
	AST_OUT32K_RUN: assert property (!o_slow_osc_run [*2] |-> !o_out32k_enable)
		else $error("32k output while stopped");
	AST_DIV_ONEHOT: assert property ($onehot(o_fast_div_ratio))
		else $error("bad divide ratio");
	AST_BUS_OKAY: assert property (o_hreadyout && !o_hresp)
		else $error("bus not ready or error");
	cover property ($rose(o_slow_int_ready));
	cover property ($rose(o_out32k_enable));
	cover property ($fell(o_slow_osc_run));
endmodule
bind ioc_top ioc_top_checker u_chk (.i_mclk, .i_rst_n, .i_ulp_clk, .o_hreadyout, .o_hresp,
	.o_slow_osc_run, .o_out32k_enable, .o_slow_int_ready, .o_fast_div_ratio);
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        i_mclk, i_rst_n, i_hsel, i_hwrite, i_ulp_clk, i_slow_osc_clk;
	logic        i_standby, i_slow_clk_req, i_fast_clk_req;
	logic [11:0] i_haddr;
	logic [1:0]  i_htrans;
	logic [31:0] i_hwdata, rdata;
	wire  [31:0] o_hrdata;
	wire  [6:0]  o_slow_osc_trim;
	wire  [4:0]  o_ulp_osc_trim;
	wire  [1:0]  o_fast_freq_band;
	wire  [11:0] o_fast_osc_trim;
	wire  [3:0]  o_fast_div_ratio;
	wire         o_hreadyout, o_slow_osc_run, o_out32k_enable, o_slow_int_ready;
	wire         o_fast_osc_run, o_irq;
	int          bad_count, samples_checked, cyc, t, n;
	logic [10:0] tbl [8] = '{11'h410, 11'h413, 11'h014, 11'h416, 11'h215, 11'h614, 11'h617,
		11'h002};
	ioc_top DUT
	(
		.i_mclk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2), .i_hwdata,
		.i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp(), .i_ulp_clk,
		.i_slow_osc_clk, .i_standby, .i_slow_clk_req, .i_fast_clk_req,
		.i_ulp_trim_cal(5'h15), .i_fast_band_cal(2'h2), .i_fast_trim_cal(12'h5a3),
		.o_slow_osc_run, .o_slow_osc_trim, .o_out32k_enable, .o_slow_int_ready,
		.o_ulp_osc_trim, .o_fast_osc_run, .o_fast_freq_band, .o_fast_osc_trim,
		.o_fast_div_ratio, .o_irq
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge i_mclk);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_hwrite <= w;
		i_haddr <= a;
		do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
		rdata = o_hrdata;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		chk(rdata, exp);
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge i_mclk);
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	// Oscillator pins and timeout
	always @(posedge i_mclk)
	begin
		cyc <= cyc + 1;
		i_ulp_clk <= cyc[2];
		i_slow_osc_clk <= cyc[1];
		if (cyc == 20000)
		begin
			bad_count++;
			end_of_test;
		end
	end
	initial
	begin
		{i_rst_n, i_hsel, i_hwrite, i_ulp_clk, i_slow_osc_clk} = 5'h0;
		{i_standby, i_slow_clk_req, i_fast_clk_req, i_htrans, i_haddr} = 17'h0;
		i_hwdata = 32'h0;
		{bad_count, samples_checked, cyc} = '0;
		wt(10);
		i_rst_n <= 1'b1;
		wt(2);
		rc(12'h018, 32'h003f0080);
		rc(12'h020, 32'h85a30382);
		rc(12'h01c, 32'h15);
		rc(12'h040, 32'h0);
		chk({o_ulp_osc_trim, o_fast_freq_band, o_fast_osc_trim}, {5'h15, 2'h2, 12'h5a3});
		chk({o_fast_div_ratio, o_fast_osc_run}, 5'h10);
		i_fast_clk_req <= 1'b1;
		wt(3);
		chk(o_fast_osc_run, 1'b1);
		i_fast_clk_req <= 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			xfer(12'h020, 1'b1, 32'h85a30002 | (k << 8));
			wt(3);
			chk({o_fast_div_ratio, o_fast_osc_run}, (2 << k) | 1);
		end
		xfer(12'h000, 1'b1, 32'h3);
		for (int k = 0; k < 8; k++)
		begin
			n = 2 + (1 << k);
			xfer(12'h018, 1'b1, {16'h0055, 5'h0, k[2:0], 8'h06});
			t = 0;
			while (o_slow_int_ready !== 1'b1 && t < 1500)
			begin
				@(posedge i_mclk);
				t++;
			end
			chk(t >= (n - 1) * 8 && t <= n * 8 + 24, 1'b1);
			wt(2);
			chk({o_out32k_enable, o_slow_osc_trim, o_irq}, 9'h1ab);
			rc(12'h00c, 32'h1);
			xfer(12'h018, 1'b1, 32'h00550004);
			wt(4);
			chk({o_slow_osc_run, o_slow_int_ready, o_out32k_enable}, 3'h0);
			rc(12'h00c, 32'h0);
		end
		xfer(12'h000, 1'b1, 32'h0);
		wt(2);
		chk(o_irq, 1'b0);
		xfer(12'h000, 1'b1, 32'h3);
		wt(2);
		chk(o_irq, 1'b1);
		rc(12'h004, 32'h3);
		rc(12'h004, 32'h0);
		wt(2);
		chk(o_irq, 1'b0);
		foreach (tbl[i])
		begin
			{i_standby, i_slow_clk_req} <= tbl[i][2:1];
			xfer(12'h018, 1'b1, {24'h005500, tbl[i][10:3]});
			wt(3);
			chk({o_slow_osc_run, o_out32k_enable}, {tbl[i][0], 1'b0});
		end
		{i_standby, i_slow_clk_req} <= 2'h0;
		xfer(12'h01c, 1'b1, 32'h0a);
		rc(12'h01c, 32'h0a);
		xfer(12'h01c, 1'b1, 32'h8a);
		xfer(12'h01c, 1'b1, 32'h05);
		rc(12'h01c, 32'h8a);
		xfer(12'h018, 1'b1, 32'h00551006);
		xfer(12'h018, 1'b1, 32'h0);
		rc(12'h018, 32'h00551006);
		chk(o_slow_osc_run, 1'b1);
		i_rst_n <= 1'b0;
		wt(10);
		i_rst_n <= 1'b1;
		wt(2);
		rc(12'h018, 32'h003f0080);
		rc(12'h01c, 32'h15);
		end_of_test;
	end
endmodule
`default_nettype wire
